// ===== logic/ddc_ctrl.sv
// controller end: takes user requests, spaces commands by down-counters, drives cke and strobes
// assumes the memory end samples the link on the same clk_sys edge that follows each drive
`timescale 1ns/1ps
`include "ddc_consts.svh"

module ddc_ctrl #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16,
  parameter int DEPTH  = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  ddc_link_if.ctrl               link,
  input  wire logic              req_valid,
  input  ddc_pkg::ddc_op_t       req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic              req_skew,
  output logic                   req_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_bad,
  output logic                   down
);

  localparam int IDX_W = $clog2(DEPTH);
  localparam ddc_pkg::ddc_cnt_t TRP_NCK = ddc_pkg::ddc_cnt_t'(ddc_pkg::ru_cycles(`DDC_TRP_NS, `DDC_TCK_NS));
  localparam ddc_pkg::ddc_cnt_t WTR_NCK = ddc_pkg::ddc_cnt_t'(`DDC_WTR_NCK);
  localparam ddc_pkg::ddc_cnt_t CKE_NCK = ddc_pkg::ddc_cnt_t'(`DDC_CKE_NCK);
  localparam ddc_pkg::ddc_cnt_t XP_NCK  = ddc_pkg::ddc_cnt_t'(`DDC_XP_NCK);
  localparam ddc_pkg::ddc_cnt_t ONE     = ddc_pkg::ddc_cnt_t'(1);

  typedef enum logic {CT_UP, CT_DOWN} ddc_ct_st_t;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  ddc_ct_st_t           st_reg,     st_next;
  logic                 cke_reg,    cke_next;
  ddc_pkg::ddc_cmd_t    cmd_reg,    cmd_next;
  logic [ADDR_W-1:0]    addr_reg,   addr_next;
  logic [DATA_W-1:0]    wdata_reg,  wdata_next;
  logic [DATA_W-1:0]    wbuf_reg,   wbuf_next;
  logic                 dqst_reg,   dqst_next;
  logic                 dqsc_reg,   dqsc_next;
  logic                 wpend_reg,  wpend_next;
  logic                 skew_reg,   skew_next;
  logic [IDX_W-1:0]     widx_reg,   widx_next;
  logic [`DDC_MR_W-1:0] mr_reg,     mr_next;
  logic [DEPTH-1:0]     bad_reg,    bad_next;
  ddc_pkg::ddc_cnt_t    cany_reg,   cany_next;
  ddc_pkg::ddc_cnt_t    crd_reg,    crd_next;
  ddc_pkg::ddc_cnt_t    cact_reg,   cact_next;
  ddc_pkg::ddc_cnt_t    ccke_reg,   ccke_next;
  logic                 rdv_reg,    rdv_next;
  logic [DATA_W-1:0]    rdd_reg,    rdd_next;
  logic                 rdb_reg,    rdb_next;
  ddc_pkg::ddc_cnt_t    ld_any;
  ddc_pkg::ddc_cnt_t    ld_rd;
  ddc_pkg::ddc_cnt_t    ld_act;
  ddc_pkg::ddc_cnt_t    ld_cke;
  logic                 single;
  logic                 take;
  logic [IDX_W-1:0]     ridx;

  assign single = mr_reg[`DDC_MR_STROBE_BIT];
  assign ridx   = req_addr[IDX_W-1:0];
  assign take   = req_valid & req_ready;

  // --------------------------------------------------------------------------
  // request gating
  // --------------------------------------------------------------------------
  // a request is held off, never dropped, while its counter runs
  always_comb begin
    req_ready = 1'b0;
    if (st_reg == CT_DOWN) begin
      req_ready = (req_op == ddc_pkg::DDC_OP_PDX) && (ccke_reg == '0);
    end else if (cany_reg == '0) begin
      case (req_op)
        ddc_pkg::DDC_OP_RD:  req_ready = (crd_reg == '0) & ~link.rvalid;
        ddc_pkg::DDC_OP_ACT: req_ready = (cact_reg == '0);
        ddc_pkg::DDC_OP_PDE: req_ready = (ccke_reg == '0);
        ddc_pkg::DDC_OP_PDX: req_ready = 1'b0;
        default:             req_ready = 1'b1;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    cke_next   = cke_reg;
    cmd_next   = ddc_pkg::DDC_NOP;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    wbuf_next  = wbuf_reg;
    wpend_next = 1'b0;
    skew_next  = skew_reg;
    widx_next  = widx_reg;
    mr_next    = mr_reg;
    bad_next   = bad_reg;
    rdv_next   = link.rvalid;
    rdd_next   = link.rdata;
    rdb_next   = link.rbad;
    ld_any     = '0;
    ld_rd      = '0;
    ld_act     = '0;
    ld_cke     = '0;
    // idle strobes: true low, complement high in differential mode, unused when single
    dqst_next  = 1'b0;
    dqsc_next  = ~single;
    if (wpend_reg) begin
      wdata_next = wbuf_reg;
      dqst_next  = ~(single & skew_reg);
      dqsc_next  = ~single & skew_reg;
      widx_next  = addr_reg[IDX_W-1:0];
    end
    // fault arrives one edge after the data slot; a newer write to that location already in flight wins
    if (link.wr_fault && !(wpend_reg && addr_reg[IDX_W-1:0] == widx_reg)) begin
      bad_next[widx_reg] = 1'b1;
    end
    if (take) begin
      case (req_op)
        ddc_pkg::DDC_OP_RD: begin
          if (bad_reg[ridx]) begin
            rdv_next = 1'b1;
            rdd_next = '0;
            rdb_next = 1'b1;
          end else begin
            cmd_next  = ddc_pkg::DDC_RD;
            addr_next = req_addr;
          end
        end
        ddc_pkg::DDC_OP_WR, ddc_pkg::DDC_OP_WRA: begin
          cmd_next        = (req_op == ddc_pkg::DDC_OP_WRA) ? ddc_pkg::DDC_WRA : ddc_pkg::DDC_WR;
          addr_next       = req_addr;
          wbuf_next       = req_data;
          wpend_next      = 1'b1;
          skew_next       = req_skew;
          bad_next[ridx]  = 1'b0;
          ld_any          = ONE;
          // data lands one clock after the command; the read wait counts from its end
          ld_rd           = ONE + WTR_NCK;
          if (req_op == ddc_pkg::DDC_OP_WRA) begin
            ld_act = ONE + ddc_pkg::ddc_cnt_t'(mr_reg[`DDC_MR_WR_MSB:`DDC_MR_WR_LSB]) + TRP_NCK;
          end
        end
        ddc_pkg::DDC_OP_ACT: begin
          cmd_next  = ddc_pkg::DDC_ACT;
          addr_next = req_addr;
        end
        ddc_pkg::DDC_OP_PRE: begin
          cmd_next  = ddc_pkg::DDC_PRE;
          addr_next = req_addr;
          ld_act    = TRP_NCK - ONE;
        end
        ddc_pkg::DDC_OP_MRS: begin
          cmd_next  = ddc_pkg::DDC_MRS;
          addr_next = req_addr;
          mr_next   = req_addr[`DDC_MR_W-1:0];
        end
        ddc_pkg::DDC_OP_PDE: begin
          cke_next = 1'b0;
          st_next  = CT_DOWN;
          ld_cke   = CKE_NCK - ONE;
        end
        ddc_pkg::DDC_OP_PDX: begin
          cke_next = 1'b1;
          st_next  = CT_UP;
          ld_cke   = CKE_NCK - ONE;
          // exit registers on the third edge, then active waits two more
          ld_act   = CKE_NCK + XP_NCK - ONE;
          ld_any   = CKE_NCK;
        end
        default: begin
        end
      endcase
    end
    cany_next = ddc_pkg::cnt_step(cany_reg, ld_any);
    crd_next  = ddc_pkg::cnt_step(crd_reg, ld_rd);
    cact_next = ddc_pkg::cnt_step(cact_reg, ld_act);
    ccke_next = ddc_pkg::cnt_step(ccke_reg, ld_cke);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg    <= CT_UP;
      cke_reg   <= 1'b1;
      cmd_reg   <= ddc_pkg::DDC_NOP;
      addr_reg  <= '0;
      wdata_reg <= '0;
      wbuf_reg  <= '0;
      dqst_reg  <= 1'b0;
      dqsc_reg  <= 1'b1;
      wpend_reg <= 1'b0;
      skew_reg  <= 1'b0;
      widx_reg  <= '0;
      mr_reg    <= `DDC_MR_RST;
      bad_reg   <= '0;
      cany_reg  <= '0;
      crd_reg   <= '0;
      cact_reg  <= '0;
      ccke_reg  <= '0;
      rdv_reg   <= 1'b0;
      rdd_reg   <= '0;
      rdb_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cke_reg   <= cke_next;
      cmd_reg   <= cmd_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      wbuf_reg  <= wbuf_next;
      dqst_reg  <= dqst_next;
      dqsc_reg  <= dqsc_next;
      wpend_reg <= wpend_next;
      skew_reg  <= skew_next;
      widx_reg  <= widx_next;
      mr_reg    <= mr_next;
      bad_reg   <= bad_next;
      cany_reg  <= cany_next;
      crd_reg   <= crd_next;
      cact_reg  <= cact_next;
      ccke_reg  <= ccke_next;
      rdv_reg   <= rdv_next;
      rdd_reg   <= rdd_next;
      rdb_reg   <= rdb_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign link.cke   = cke_reg;
  assign link.cmd   = cmd_reg;
  assign link.addr  = addr_reg;
  assign link.wdata = wdata_reg;
  assign link.dqs_t = dqst_reg;
  assign link.dqs_c = dqsc_reg;
  assign rd_valid   = rdv_reg;
  assign rd_data    = rdd_reg;
  assign rd_bad     = rdb_reg;
  assign down       = (st_reg == CT_DOWN);

endmodule // ddc_ctrl

// ===== logic/ddc_consts.svh
// timing and field constants for the ddr2 command link, controller and memory ends
// assumes a single 100 MHz clock shared by both ends; included by bare name
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH

// ----------------------------------------------------------------------------
// clock and time figures
// ----------------------------------------------------------------------------
`define DDC_TCK_NS        10
`define DDC_TRP_NS        15
`define DDC_WTR_NCK       2
`define DDC_CKE_NCK       3
`define DDC_XP_NCK        2

// ----------------------------------------------------------------------------
// mode register layout and reset value
// ----------------------------------------------------------------------------
`define DDC_MR_W          14
`define DDC_MR_STROBE_BIT 10
`define DDC_MR_WR_LSB     0
`define DDC_MR_WR_MSB     2
`define DDC_MR_RST        14'h0004

// ----------------------------------------------------------------------------
// counter width
// ----------------------------------------------------------------------------
`define DDC_CNT_W         5

`endif

// ===== logic/ddc_pkg.sv
// types and helper functions shared by both ends of the ddr2 command link
// assumes ddc_consts.svh is on the include path
`include "ddc_consts.svh"

package ddc_pkg;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef logic [`DDC_CNT_W-1:0] ddc_cnt_t;

  typedef enum logic [2:0] {
    DDC_NOP,
    DDC_ACT,
    DDC_RD,
    DDC_WR,
    DDC_WRA,
    DDC_PRE,
    DDC_MRS
  } ddc_cmd_t;

  typedef enum logic [2:0] {
    DDC_OP_RD,
    DDC_OP_WR,
    DDC_OP_WRA,
    DDC_OP_ACT,
    DDC_OP_PRE,
    DDC_OP_MRS,
    DDC_OP_PDE,
    DDC_OP_PDX
  } ddc_op_t;

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // time to whole clocks, rounded up, never below one
  function automatic int ru_cycles(input int t_ns, input int tck_ns);
    int c;
    c = (t_ns + tck_ns - 1) / tck_ns;
    return (c < 1) ? 1 : c;
  endfunction

  // down-counter step that also accepts a new load, keeping the longer wait
  function automatic ddc_cnt_t cnt_step(input ddc_cnt_t cur, input ddc_cnt_t ld);
    ddc_cnt_t d;
    d = (cur == '0) ? '0 : cur - ddc_cnt_t'(1);
    return (ld > d) ? ld : d;
  endfunction

endpackage

// ===== logic/ddc_link_if.sv
// command, clock-enable and data link between the controller end and the memory end
// assumes both ends run on the same clk_sys; no clocking block here
`timescale 1ns/1ps

interface ddc_link_if #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16
);
  logic                   cke;
  ddc_pkg::ddc_cmd_t      cmd;
  logic [ADDR_W-1:0]      addr;
  logic [DATA_W-1:0]      wdata;
  logic                   dqs_t;
  logic                   dqs_c;
  logic [DATA_W-1:0]      rdata;
  logic                   rvalid;
  logic                   rbad;
  logic                   wr_fault;

  modport ctrl (
    output cke,
    output cmd,
    output addr,
    output wdata,
    output dqs_t,
    output dqs_c,
    input  rdata,
    input  rvalid,
    input  rbad,
    input  wr_fault
  );

  modport dram (
    input  cke,
    input  cmd,
    input  addr,
    input  wdata,
    input  dqs_t,
    input  dqs_c,
    output rdata,
    output rvalid,
    output rbad,
    output wr_fault
  );
endinterface // ddc_link_if

// ===== logic/ddc_dram.sv
// memory end: registers cke, decodes commands, checks spacing, stores write data
// assumes the controller end drives the link from its flops on the same clk_sys
`timescale 1ns/1ps
`include "ddc_consts.svh"

module ddc_dram #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16,
  parameter int DEPTH  = 16
) (
  input  wire logic   clk_sys,
  input  wire logic   arst_n,
  ddc_link_if.dram    link,
  output logic        single_strobe,
  output logic        powered_down,
  output logic        err_cke,
  output logic        err_act,
  output logic        err_wtr,
  output logic        err_cmd
);

  localparam int IDX_W = $clog2(DEPTH);
  localparam ddc_pkg::ddc_cnt_t TRP_NCK = ddc_pkg::ddc_cnt_t'(ddc_pkg::ru_cycles(`DDC_TRP_NS, `DDC_TCK_NS));
  localparam ddc_pkg::ddc_cnt_t WTR_NCK = ddc_pkg::ddc_cnt_t'(`DDC_WTR_NCK);
  localparam ddc_pkg::ddc_cnt_t CKE_NCK = ddc_pkg::ddc_cnt_t'(`DDC_CKE_NCK);
  localparam ddc_pkg::ddc_cnt_t XP_NCK  = ddc_pkg::ddc_cnt_t'(`DDC_XP_NCK);
  localparam ddc_pkg::ddc_cnt_t ONE     = ddc_pkg::ddc_cnt_t'(1);

  typedef enum logic {DEV_UP, DEV_DOWN} ddc_dev_st_t;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  ddc_dev_st_t          st_reg,      st_next;
  ddc_pkg::ddc_cnt_t    ckecnt_reg,  ckecnt_next;
  ddc_pkg::ddc_cnt_t    actcnt_reg,  actcnt_next;
  ddc_pkg::ddc_cnt_t    wtrcnt_reg,  wtrcnt_next;
  logic [`DDC_MR_W-1:0] mr_reg,      mr_next;
  logic                 wpend_reg,   wpend_next;
  logic                 wauto_reg,   wauto_next;
  logic [IDX_W-1:0]     widx_reg,    widx_next;
  logic [DATA_W-1:0]    rdata_reg,   rdata_next;
  logic                 rvalid_reg,  rvalid_next;
  logic                 rbad_reg,    rbad_next;
  logic                 fault_reg,   fault_next;
  logic [DEPTH-1:0]     bad_reg,     bad_next;
  logic [3:0]           err_reg,     err_next;
  logic [DATA_W-1:0]    mem [DEPTH];
  logic                 mem_we;
  logic                 strobe_ok;
  logic [IDX_W-1:0]     cidx;
  ddc_pkg::ddc_cnt_t    act_ld;
  ddc_pkg::ddc_cnt_t    wtr_ld;

  assign cidx = link.addr[IDX_W-1:0];

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_next     = st_reg;
    ckecnt_next = '0;
    mr_next     = mr_reg;
    wpend_next  = 1'b0;
    wauto_next  = wauto_reg;
    widx_next   = widx_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    rbad_next   = 1'b0;
    fault_next  = 1'b0;
    bad_next    = bad_reg;
    err_next    = err_reg;
    mem_we      = 1'b0;
    act_ld      = '0;
    wtr_ld      = '0;
    // single-ended strobe uses the true strobe only; differential needs a crossing
    strobe_ok   = mr_reg[`DDC_MR_STROBE_BIT] ? link.dqs_t : (link.dqs_t & ~link.dqs_c);
    // a level counts only after three consecutive edges at that level
    if (link.cke != (st_reg == DEV_UP)) begin
      ckecnt_next = ckecnt_reg + ONE;
      if (ckecnt_reg == CKE_NCK - ONE) begin
        ckecnt_next = '0;
        st_next     = (st_reg == DEV_UP) ? DEV_DOWN : DEV_UP;
        if (st_reg == DEV_DOWN) begin
          act_ld = XP_NCK - ONE;
        end
      end
    end else if (ckecnt_reg != '0) begin
      err_next[0] = 1'b1;
    end
    if (st_reg == DEV_DOWN) begin
      if (link.cmd != ddc_pkg::DDC_NOP) begin
        err_next[3] = 1'b1;
      end
    end else begin
      case (link.cmd)
        ddc_pkg::DDC_ACT: begin
          // spacing is judged in counted edges, not elapsed time
          if (actcnt_reg != '0) begin
            err_next[1] = 1'b1;
          end
        end
        ddc_pkg::DDC_RD: begin
          if (wtrcnt_reg != '0) begin
            err_next[2] = 1'b1;
          end else begin
            rvalid_next = 1'b1;
            rdata_next  = mem[cidx];
            rbad_next   = bad_reg[cidx];
          end
        end
        ddc_pkg::DDC_WR, ddc_pkg::DDC_WRA: begin
          wpend_next = 1'b1;
          widx_next  = cidx;
          wauto_next = (link.cmd == ddc_pkg::DDC_WRA);
        end
        ddc_pkg::DDC_PRE: begin
          act_ld = TRP_NCK - ONE;
        end
        ddc_pkg::DDC_MRS: begin
          mr_next = link.addr[`DDC_MR_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (wpend_reg) begin
      mem_we             = 1'b1;
      bad_next[widx_reg] = ~strobe_ok;
      fault_next         = ~strobe_ok;
      wtr_ld             = WTR_NCK - ONE;
      if (wauto_reg) begin
        act_ld = ddc_pkg::ddc_cnt_t'(mr_reg[`DDC_MR_WR_MSB:`DDC_MR_WR_LSB]) + TRP_NCK - ONE;
      end
    end
    actcnt_next = ddc_pkg::cnt_step(actcnt_reg, act_ld);
    wtrcnt_next = ddc_pkg::cnt_step(wtrcnt_reg, wtr_ld);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg     <= DEV_UP;
      ckecnt_reg <= '0;
      actcnt_reg <= '0;
      wtrcnt_reg <= '0;
      mr_reg     <= `DDC_MR_RST;
      wpend_reg  <= 1'b0;
      wauto_reg  <= 1'b0;
      widx_reg   <= '0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      rbad_reg   <= 1'b0;
      fault_reg  <= 1'b0;
      bad_reg    <= '0;
      err_reg    <= '0;
    end else begin
      st_reg     <= st_next;
      ckecnt_reg <= ckecnt_next;
      actcnt_reg <= actcnt_next;
      wtrcnt_reg <= wtrcnt_next;
      mr_reg     <= mr_next;
      wpend_reg  <= wpend_next;
      wauto_reg  <= wauto_next;
      widx_reg   <= widx_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      rbad_reg   <= rbad_next;
      fault_reg  <= fault_next;
      bad_reg    <= bad_next;
      err_reg    <= err_next;
    end
  end

  // storage needs no reset; the bad bits reset clear, so unwritten content reads as good, not bad
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[widx_reg] <= link.wdata;
    end
  end

  assign link.rdata    = rdata_reg;
  assign link.rvalid   = rvalid_reg;
  assign link.rbad     = rbad_reg;
  assign link.wr_fault = fault_reg;
  assign single_strobe = mr_reg[`DDC_MR_STROBE_BIT];
  assign powered_down  = (st_reg == DEV_DOWN);
  assign err_cke       = err_reg[0];
  assign err_act       = err_reg[1];
  assign err_wtr       = err_reg[2];
  assign err_cmd       = err_reg[3];

endmodule // ddc_dram

// ===== dv/ddc_checker.sv
// link checker: command spacing, cke holds, strobes
// assumes both ends share clk_sys
`timescale 1ns/1ps
`include "ddc_consts.svh"
module ddc_checker (
  input wire logic         clk_sys,
  input wire logic         arst_n,
  input wire logic         cke,
  input ddc_pkg::ddc_cmd_t cmd,
  input wire logic [13:0]  addr,
  input wire logic         dqs_t,
  input wire logic         dqs_c,
  input wire logic         rvalid,
  input wire logic         wr_fault
);
  // ---
  // mode copy, data slot, auto-precharge wait
  // ---
  logic [13:0] mr_reg;
  logic        slot_reg;
  logic [3:0]  dal_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mr_reg <= `DDC_MR_RST;
      slot_reg <= 1'b0;
      dal_reg <= 4'h0;
    end else begin
      if (cmd == ddc_pkg::DDC_MRS) mr_reg <= addr;
      slot_reg <= cmd inside {ddc_pkg::DDC_WR, ddc_pkg::DDC_WRA};
      // wr plus two for precharge, plus one for the data slot
      if (cmd == ddc_pkg::DDC_WRA) dal_reg <= {1'b0, mr_reg[2:0]} + 4'h3;
      else if (dal_reg != 4'h0) dal_reg <= dal_reg - 4'h1;
    end
  end
  chk_wtr_gap:
    assert property (cmd inside {ddc_pkg::DDC_WR, ddc_pkg::DDC_WRA} |=> (cmd != ddc_pkg::DDC_RD) [*3])
    else $error("read too soon after write");
  chk_cke_hold:
    assert property ($changed(cke) |=> $stable(cke) [*2]) else $error("cke level too short");
  chk_down_quiet:
    assert property (!cke |-> cmd == ddc_pkg::DDC_NOP) else $error("command with cke low");
  chk_pre_act:
    assert property (cmd == ddc_pkg::DDC_PRE |=> cmd != ddc_pkg::DDC_ACT) else $error("act too soon");
  chk_dal_wait:
    assert property (cmd == ddc_pkg::DDC_ACT |-> dal_reg == 4'h0) else $error("act inside recovery");
  chk_exit_act:
    assert property ($rose(cke) |-> (cmd != ddc_pkg::DDC_ACT) [*5]) else $error("act too soon after exit");
  chk_data_slot:
    assert property (slot_reg |-> cmd == ddc_pkg::DDC_NOP) else $error("command in data slot");
  chk_strobe_idle:
    assert property (!slot_reg && cmd != ddc_pkg::DDC_MRS |-> !dqs_t && dqs_c == !mr_reg[10])
    else $error("strobe idle level");
  chk_fault_flag:
    assert property (slot_reg && !(dqs_t && (mr_reg[10] || !dqs_c)) |=> wr_fault) else $error("fault missed");
  chk_fault_cause:
    assert property (wr_fault |-> $past(slot_reg)) else $error("fault without write");
  chk_read_answer:
    assert property (rvalid == ($past(cmd) == ddc_pkg::DDC_RD)) else $error("read answer timing");
  cover property (wr_fault);
  cover property ($rose(cke));
  cover property (cmd == ddc_pkg::DDC_WRA);
endmodule // ddc_checker

// ===== dv/tb.sv
// bench: controller and memory ends joined by the link
// assumes design files compiled first
`timescale 1ns/1ps
module tb;
  // ---
  // signals and instances
  // ---
  logic             clk_sys = 1'b0;
  logic             arst_n, req_valid, req_skew, req_ready, rd_valid, rd_bad, down;
  logic             single_strobe, powered_down, err_cke, err_act, err_wtr, err_cmd;
  ddc_pkg::ddc_op_t req_op;
  logic [13:0]      req_addr;
  logic [15:0]      req_data, rd_data, r;
  logic [15:0]      mem [16];
  logic             bad [16];
  int               n_fail = 0, checks_done = 0, cyc = 0;
  ddc_link_if link ();
  ddc_ctrl i_ddc_ctrl (.clk_sys, .arst_n, .link, .req_valid, .req_op, .req_addr, .req_data,
    .req_skew, .req_ready, .rd_valid, .rd_data, .rd_bad, .down);
  ddc_dram i_ddc_dram (.clk_sys, .arst_n, .link, .single_strobe, .powered_down, .err_cke,
    .err_act, .err_wtr, .err_cmd);
  ddc_checker i_ddc_checker (.clk_sys, .arst_n, .cke(link.cke), .cmd(link.cmd), .addr(link.addr),
    .dqs_t(link.dqs_t), .dqs_c(link.dqs_c), .rvalid(link.rvalid), .wr_fault(link.wr_fault));
  always #5 clk_sys = ~clk_sys;
  // ---
  // tasks
  // ---
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic summarize();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // valid stays up after the take so requests can go back to back
  task automatic op(input ddc_pkg::ddc_op_t o, input logic [13:0] a, input logic [15:0] d, input logic s);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_data <= d;
    req_skew <= s;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n < 200, "request stalled");
    @(posedge clk_sys);
  endtask
  task automatic wr(input ddc_pkg::ddc_op_t o, input logic [3:0] i, input logic [15:0] d, input logic s);
    op(o, {10'h000, i}, d, s);
    mem[i] = d;
    bad[i] = s;
  endtask
  task automatic rd(input logic [3:0] i);
    op(ddc_pkg::DDC_OP_RD, {10'h000, i}, 16'h0000, 1'b0);
    req_valid <= 1'b0;
    // a local answer stands right after the take, a link answer two edges later
    repeat (bad[i] ? 0 : 2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(rd_valid === 1'b1 && rd_bad === bad[i], "read flags");
    chk(rd_data === (bad[i] ? 16'h0000 : mem[i]), "read data");
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ---
  // sequence
  // ---
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_op = ddc_pkg::DDC_OP_RD;
    req_addr = 14'h0000;
    req_data = 16'h0000;
    req_skew = 1'b0;
    r = 16'h6b4f;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    chk(down === 1'b0 && single_strobe === 1'b0, "reset state");
    for (int i = 0; i < 16; i++) wr(ddc_pkg::DDC_OP_WR, 4'(i), 16'h1000 + 16'(i), 1'b0);
    for (int m = 1; m >= 0; m--) begin
      op(ddc_pkg::DDC_OP_MRS, {3'h0, 1'(m), 7'h00, 3'(4 - m)}, 16'h0000, 1'b0);
      req_valid <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(single_strobe === 1'(m), "strobe mode");
      @(posedge clk_sys);
      // random mix; skewed strobes mark locations bad until rewritten
      for (int i = 0; i < 40; i++) begin
        r = nxt(r);
        case (r[6:4])
          3'h0, 3'h1: wr(ddc_pkg::DDC_OP_WR, r[3:0], r ^ 16'h5a5a, r[9:7] == 3'h0);
          3'h2: wr(ddc_pkg::DDC_OP_WRA, r[3:0], ~r, r[9:7] == 3'h1);
          3'h5: op(ddc_pkg::DDC_OP_ACT, {10'h000, r[3:0]}, 16'h0000, 1'b0);
          3'h6: op(ddc_pkg::DDC_OP_PRE, {10'h000, r[3:0]}, 16'h0000, 1'b0);
          default: rd(r[3:0]);
        endcase
      end
    end
    req_valid <= 1'b0;
    req_op <= ddc_pkg::DDC_OP_PDX;
    @(negedge clk_sys);
    chk(req_ready === 1'b0, "exit taken while up");
    @(posedge clk_sys);
    op(ddc_pkg::DDC_OP_PDE, 14'h0000, 16'h0000, 1'b0);
    req_valid <= 1'b0;
    req_op <= ddc_pkg::DDC_OP_RD;
    repeat (5) @(negedge clk_sys);
    chk(down === 1'b1 && powered_down === 1'b1 && req_ready === 1'b0, "power-down");
    @(posedge clk_sys);
    op(ddc_pkg::DDC_OP_PDX, 14'h0000, 16'h0000, 1'b0);
    op(ddc_pkg::DDC_OP_ACT, 14'h0001, 16'h0000, 1'b0);
    req_valid <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(down === 1'b0 && powered_down === 1'b0, "power-up");
    chk({err_cke, err_act, err_wtr, err_cmd} === 4'h0, "link spacing");
    summarize();
  end
endmodule // tb
